// ===== rtl/mmc_pkg.sv
// Package with register map, reset values and carrier types of the metering mode block
package mmc_pkg;
  // Register indices; the APB byte address is four times the index
  localparam logic [15:0] MMC_IDX_CFG   = 16'hE618; // General configuration
  localparam logic [15:0] MMC_IDX_MM    = 16'hE700; // Measurement mode
  localparam logic [15:0] MMC_IDX_AM    = 16'hE701; // Accumulation mode
  localparam logic [15:0] MMC_IDX_PCYC  = 16'hE703; // Peak period in half cycles
  localparam logic [15:0] MMC_IDX_VPK   = 16'hE704; // Voltage peak (read only)
  localparam logic [15:0] MMC_IDX_IPK   = 16'hE705; // Current peak (read only)
  localparam logic [15:0] MMC_IDX_BRMS  = 16'hE706; // Phase B voltage rms (read only)
  // Values after reset
  localparam logic [15:0] MMC_CFG_RST  = 16'h0002;
  localparam logic [7:0]  MMC_MM_RST   = 8'h1C;
  localparam logic [7:0]  MMC_AM_RST   = 8'h00;
  localparam logic [7:0]  MMC_PCYC_RST = 8'h00;
  // Field positions
  localparam int MMC_PAIR_LSB = 12; // Phase C voltage pairing, 2 bits
  localparam int MMC_PEAK_LSB = 2;  // Peak phase select, 3 bits
  localparam int MMC_ACT_LSB  = 0;  // Active accumulation method, 2 bits
  localparam int MMC_VAR_LSB  = 2;  // Reactive accumulation method, 2 bits
  localparam int MMC_TOPO_LSB = 4;  // Wiring topology select, 2 bits
  localparam int MMC_RMS_SHIFT = 4; // Smoothing shift of the rms estimate
  // Writable bits of measurement mode; bits 1:0 and 7:5 have no function
  localparam logic [7:0]  MMC_MM_WMASK = 8'h1C;

  // One sample set: phase voltages, currents and -90 degree shifted currents
  typedef struct packed {
    logic signed [2:0][15:0] v;
    logic signed [2:0][15:0] i;
    logic signed [2:0][15:0] iq;
  } mmc_samp_s;

  // Active and reactive accumulators per phase
  typedef struct packed {
    logic [2:0][31:0] act;
    logic [2:0][31:0] react;
  } mmc_energy_s;
endpackage

// ===== rtl/mmc_core.sv
// Metering mode configuration registers and the power path they steer
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
//
// Functional notes
// - Phase C pairing code picks C, A or B
// - Pairing code 11 acts as 00
// - Peak select bits per phase, reset set
// - Multiple peak phases shorten the peak period
// - Reserved measurement mode bits do nothing, zero
// - Active code 00 signed for energy and pulses
// - Active code 01 positive energy, signed pulses
// - Active code 10 behaves as 00
// - Active code 11 absolute for energy and pulses
// - Reactive code 00 signed everywhere
// - Reactive code 01 behaves as 00
// - Reactive code 10 follows active power sign for energy, signed pulses
// - Reactive code 11 absolute energy, signed pulses
// - Topology selects energy inputs via the phase B voltage only
// - Topology codes reshape phase B voltage
// - Three-wire delta rms holds VA minus VC
module mmc_core
  import mmc_pkg::*;
(
  input  wire logic              pclk,        // System clock, 200 MHz
  input  wire logic              presetn,     // Asynchronous reset, active low
  input  wire logic              psel,        // APB select
  input  wire logic              penable,     // APB access phase
  input  wire logic              pwrite,      // APB write
  input  wire logic [19:0]       paddr,       // APB byte address
  input  wire logic [31:0]       pwdata,      // APB write data
  output logic      [31:0]       prdata,      // APB read data
  output logic                   pready,      // APB ready
  output logic                   pslverr,     // APB error on unmapped address
  input  wire logic              samp_valid,  // New sample set strobe
  input  wire mmc_samp_s         samp,        // Sample set
  input  wire logic [2:0]        zero_cross,  // Zero crossing pulses per phase
  output mmc_energy_s            energy,      // Energy register accumulators
  output mmc_energy_s            pulse_acc,   // Accumulators feeding the pulse outputs
  output logic      [15:0]       volt_peak,   // Latched voltage peak
  output logic      [15:0]       curr_peak,   // Latched current peak
  output logic      [15:0]       phase_b_voltage_rms // Phase B voltage rms
);

  // Absolute value of a 16-bit sample
  // The most negative code maps to 8000 hex, read back as an unsigned magnitude
  function automatic logic [15:0] mag16(input logic signed [15:0] x);
    mag16 = x[15] ? 16'(-x) : x;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB slave
  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] cfg_q;        // General configuration
  logic [7:0]  mm_q;         // Measurement mode
  logic [7:0]  am_q;         // Accumulation mode
  logic [7:0]  pcyc_q;       // Peak period
  logic [15:0] vpk_q;        // Latched voltage peak
  logic [15:0] ipk_q;        // Latched current peak
  logic [15:0] brms_q;       // Phase B rms estimate
  logic [31:0] prdata_q;     // Read data register
  logic        pready_q;     // Ready register
  logic        pslverr_q;    // Error register

  // Misaligned or unmapped addresses read zero and flag an error
  wire         addr_ok  = paddr[1:0] == 2'h0;
  wire  [17:0] idx      = paddr[19:2];
  wire         hit_cfg  = addr_ok && idx == {2'h0, MMC_IDX_CFG};
  wire         hit_mm   = addr_ok && idx == {2'h0, MMC_IDX_MM};
  wire         hit_am   = addr_ok && idx == {2'h0, MMC_IDX_AM};
  wire         hit_pcyc = addr_ok && idx == {2'h0, MMC_IDX_PCYC};
  wire         hit_vpk  = addr_ok && idx == {2'h0, MMC_IDX_VPK};
  wire         hit_ipk  = addr_ok && idx == {2'h0, MMC_IDX_IPK};
  wire         hit_brms = addr_ok && idx == {2'h0, MMC_IDX_BRMS};
  wire         hit_any  = hit_cfg | hit_mm | hit_am | hit_pcyc | hit_vpk | hit_ipk
                        | hit_brms;
  wire         setup    = psel && !penable;
  // Write lands only in the access cycle that completes the transfer
  wire         wr_en    = psel && penable && pready_q && pwrite;
  wire  [31:0] rd_w     = hit_cfg  ? {16'h0000, cfg_q}  :
                          hit_mm   ? {24'h000000, mm_q} :
                          hit_am   ? {24'h000000, am_q} :
                          hit_pcyc ? {24'h000000, pcyc_q} :
                          hit_vpk  ? {16'h0000, vpk_q}  :
                          hit_ipk  ? {16'h0000, ipk_q}  :
                          hit_brms ? {16'h0000, brms_q} : 32'h00000000;

  // Ready rises one cycle after setup, so every transfer has no wait state
  // A write to a read-only index is dropped without raising an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !hit_any;
      if (setup && !pwrite) begin
        prdata_q <= rd_w;
      end
    end
  end

  // Writable registers; reserved measurement mode bits stay at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q  <= MMC_CFG_RST;
      mm_q   <= MMC_MM_RST;
      am_q   <= MMC_AM_RST;
      pcyc_q <= MMC_PCYC_RST;
    end else if (wr_en) begin
      if (hit_cfg)  cfg_q  <= pwdata[15:0];
      if (hit_mm)   mm_q   <= pwdata[7:0] & MMC_MM_WMASK;
      if (hit_am)   am_q   <= pwdata[7:0];
      if (hit_pcyc) pcyc_q <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field decode and input selection
  ////////////////////////////////////////////////////////////////////////////
  wire [1:0] pair_w = cfg_q[MMC_PAIR_LSB +: 2];  // Phase C voltage pairing
  wire [2:0] psel_w = mm_q[MMC_PEAK_LSB +: 3];   // Peak phase select
  wire [1:0] act_w  = am_q[MMC_ACT_LSB +: 2];    // Active accumulation method
  wire [1:0] var_w  = am_q[MMC_VAR_LSB +: 2];    // Reactive accumulation method
  wire [1:0] topo_w = am_q[MMC_TOPO_LSB +: 2];   // Wiring topology select

  logic signed [15:0] va_w, vc_w;                // Plain phase A and C voltages
  assign va_w = samp.v[0];
  assign vc_w = samp.v[2];

  // Phase B voltage as the wiring topology forms it
  logic signed [15:0] vb_w;
  assign vb_w = (topo_w == 2'b01) ? 16'(va_w - vc_w) :
                (topo_w == 2'b10) ? 16'(-va_w - vc_w) :
                (topo_w == 2'b11) ? 16'(-va_w) : samp.v[1];

  // Voltage paired with phase C current; code 11 falls back to phase C
  logic signed [15:0] vcp_w;
  assign vcp_w = (pair_w == 2'b01) ? va_w :
                 (pair_w == 2'b10) ? vb_w : vc_w;

  // Index 0 is phase A, 1 phase B and 2 the voltage paired with phase C
  logic signed [2:0][15:0] vsel_w;                          // Voltage per power term
  assign vsel_w = {vcp_w, vb_w, va_w};

  ////////////////////////////////////////////////////////////////////////////
  // Per phase power and accumulation
  ////////////////////////////////////////////////////////////////////////////
  // Totals wrap at 32 bits; software must read them before they roll over
  mmc_energy_s en_q;     // Energy accumulators
  mmc_energy_s pl_q;     // Pulse path accumulators

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ph
      logic signed [31:0] pf_w, qf_w;   // Full products
      logic signed [15:0] p_w, q_w;     // Scaled powers
      logic signed [31:0] pe_w, pp_w;   // Active terms: energy, pulse
      logic signed [31:0] qe_w, qp_w;   // Reactive terms: energy, pulse
      // Element selects of packed arrays are unsigned; restore the sign first
      assign pf_w = $signed(vsel_w[g]) * $signed(samp.i[g]);
      assign qf_w = $signed(vsel_w[g]) * $signed(samp.iq[g]);
      assign p_w  = pf_w[30:15];
      assign q_w  = qf_w[30:15];
      // Active: 01 clips negatives for energy only, 11 is absolute for both
      assign pe_w = (act_w == 2'b11) ? 32'(mag16(p_w)) :
                    (act_w == 2'b01 && p_w < 0) ? 32'h00000000 :
                    32'(p_w);
      assign pp_w = (act_w == 2'b11) ? 32'(mag16(p_w)) : 32'(p_w);
      // Reactive: pulses always signed
      assign qe_w = (var_w == 2'b11) ? 32'(mag16(q_w)) :
                    (var_w == 2'b10 && p_w < 0) ? 32'(-q_w) :
                    32'(q_w);
      assign qp_w = 32'(q_w);

      // Only new samples add; existing totals are never rewritten
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          en_q.act[g]   <= 32'h00000000;
          en_q.react[g] <= 32'h00000000;
          pl_q.act[g]   <= 32'h00000000;
          pl_q.react[g] <= 32'h00000000;
        end else if (samp_valid) begin
          en_q.act[g]   <= en_q.act[g] + pe_w;
          en_q.react[g] <= en_q.react[g] + qe_w;
          pl_q.act[g]   <= pl_q.act[g] + pp_w;
          pl_q.react[g] <= pl_q.react[g] + qp_w;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Peak detection over the selected phases
  ////////////////////////////////////////////////////////////////////////////
  // Peaks follow the paired voltages, so a pairing change moves the source too
  logic [15:0] vrun_q, irun_q;  // Running peaks
  logic [8:0]  zc_q;            // Half cycles seen in this period
  logic [15:0] vm_w, im_w;      // Sample maxima over selected phases
  logic [1:0]  zinc_w;          // Crossings counted this cycle

  always_comb begin
    vm_w = 16'h0000;
    im_w = 16'h0000;
    for (int k = 0; k < 3; k++) begin
      if (psel_w[k] && mag16(vsel_w[k]) > vm_w) vm_w = mag16(vsel_w[k]);
      if (psel_w[k] && mag16(samp.i[k]) > im_w) im_w = mag16(samp.i[k]);
    end
  end

  // Every selected phase adds its crossings, so the period shortens
  assign zinc_w = 2'(zero_cross[0] & psel_w[0]) + 2'(zero_cross[1] & psel_w[1])
                + 2'(zero_cross[2] & psel_w[2]);
  wire [8:0] zsum_w = zc_q + 9'(zinc_w);
  wire       pend_w = (pcyc_q != 8'h00) && (zsum_w >= {1'b0, pcyc_q});

  // Latch peaks and restart at the end of each period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zc_q   <= 9'h000;
      vrun_q <= 16'h0000;
      irun_q <= 16'h0000;
      vpk_q  <= 16'h0000;
      ipk_q  <= 16'h0000;
    end else if (pend_w) begin
      zc_q   <= 9'h000;
      vpk_q  <= vrun_q;
      ipk_q  <= irun_q;
      vrun_q <= 16'h0000;
      irun_q <= 16'h0000;
    end else begin
      zc_q <= zsum_w;
      if (samp_valid && vm_w > vrun_q) vrun_q <= vm_w;
      if (samp_valid && im_w > irun_q) irun_q <= im_w;
    end
  end

  // Phase B rms estimate by smoothing the magnitude; cheap, not a true rms
  wire [15:0] bmag_w = mag16(vb_w);
  wire signed [16:0] bdiff_w = $signed({1'b0, bmag_w} - {1'b0, brms_q}); // Distance to target
  wire [15:0]        bstep_w = 16'(bdiff_w >>> MMC_RMS_SHIFT);            // One smoothing step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brms_q <= 16'h0000;
    end else if (samp_valid) begin
      brms_q <= brms_q + bstep_w;
    end
  end

  // Output connections, all from flip-flops
  assign prdata              = prdata_q;
  assign pready              = pready_q;
  assign pslverr             = pslverr_q;
  assign energy              = en_q;
  assign pulse_acc           = pl_q;
  assign volt_peak           = vpk_q;
  assign curr_peak           = ipk_q;
  assign phase_b_voltage_rms = brms_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  ////////////////////////////////////////////////////////////////////////////
  // Single-phase checks reach into the generate scopes for the scaled powers
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pair_alt: assert property (pair_w == 2'b01 |-> vcp_w == va_w)
    else $error("phase C pairing not phase A");
  a_pair_resv: assert property (pair_w inside {2'b00, 2'b11} |-> vcp_w == vc_w)
    else $error("reserved pairing code not phase C");
  a_mm_reset: assert property ($rose(presetn) |-> mm_q == 8'h1C)
    else $error("measurement mode reset value wrong");
  a_mm_resv: assert property (mm_q[7:5] == 3'b000 && mm_q[1:0] == 2'b00)
    else $error("reserved measurement bits set");
  a_act_pos: assert property (samp_valid && act_w == 2'b01 && g_ph[1].p_w < 0
                              |=> en_q.act[1] == $past(en_q.act[1]))
    else $error("positive only mode added negative power");
  a_act_pulse: assert property (samp_valid && act_w != 2'b11
                   |=> pl_q.act[0] == 32'($past(pl_q.act[0]) + $past(32'(g_ph[0].p_w))))
    else $error("active pulse path not signed");
  a_var_sign: assert property (samp_valid && var_w == 2'b10 && g_ph[2].p_w < 0
                   |=> en_q.react[2] == 32'($past(en_q.react[2]) - $past(32'(g_ph[2].q_w))))
    else $error("reactive sign not reversed");
  a_topo_delta: assert property (topo_w == 2'b01 |-> vb_w == 16'(va_w - vc_w))
    else $error("three wire phase B voltage wrong");
  a_mm_write: assert property (wr_en && hit_mm |=> mm_q == $past(pwdata[7:0] & 8'h1C))
    else $error("measurement mode write lost");
  a_apb_ready: assert property (setup |=> pready ##1 !pready || (psel && !penable))
    else $error("ready not one cycle after setup");
  a_peak_hold: assert property (pend_w |=> vpk_q == $past(vrun_q) && ipk_q == $past(irun_q))
    else $error("peak not latched at period end");

  // Main scenarios: delta wiring, shared peak period, absolute and clipped modes
  c_delta_mode: cover property (topo_w == 2'b01 && samp_valid);
  c_peak_end: cover property (pend_w && psel_w == 3'b111);
  c_abs_mode: cover property (act_w == 2'b11 && samp_valid);
  c_act_neg: cover property (samp_valid && act_w == 2'b01 && g_ph[1].p_w < 0);
  c_bus_error: cover property (pready && pslverr);
endmodule

// ===== verif/mmc_core_bench.sv
// Self-checking bench of the metering mode block: APB tasks, sample model, peak checks
`timescale 1ns/1ps
module mmc_core_bench;
  import mmc_pkg::*;
  logic        pclk = 0;      // 200 MHz clock
  logic        presetn = 0;   // Reset, active low
  logic        psel = 0;      // APB select
  logic        penable = 0;   // APB access phase
  logic        pwrite = 0;    // APB direction
  logic [19:0] paddr = '0;    // APB byte address
  logic [31:0] pwdata = '0;   // APB write data
  logic [31:0] prdata;        // APB read data
  logic        pready;        // APB ready
  logic        pslverr;       // APB error
  logic        samp_valid = 0; // Sample strobe
  mmc_samp_s   samp = '0;     // Sample set
  logic [2:0]  zero_cross = '0; // Zero crossing pulses
  mmc_energy_s energy;        // Energy accumulators
  mmc_energy_s pulse_acc;     // Pulse path accumulators
  logic [15:0] volt_peak;     // Voltage peak
  logic [15:0] curr_peak;     // Current peak
  logic [15:0] phase_b_voltage_rms; // Phase B rms
  int          error_cnt = 0; // Mismatches
  int          n_tests = 0;   // Comparisons
  logic [31:0] ea[3] = '{0, 0, 0}; // Expected energy, active
  logic [31:0] er[3] = '{0, 0, 0}; // Expected energy, reactive
  logic [31:0] pa[3] = '{0, 0, 0}; // Expected pulse path, active
  logic [31:0] pr[3] = '{0, 0, 0}; // Expected pulse path, reactive
  logic [7:0]  am = 8'h00;    // Mirror of accumulation mode
  logic [15:0] cf = 16'h0002; // Mirror of general configuration

  mmc_core i_mmc_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .samp_valid(samp_valid), .samp(samp), .zero_cross(zero_cross),
    .energy(energy), .pulse_acc(pulse_acc), .volt_peak(volt_peak), .curr_peak(curr_peak),
    .phase_b_voltage_rms(phase_b_voltage_rms));

  initial begin
    forever #2.5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One value against its expectation, four-state exact
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  // Request held until pready is seen high; data taken from that same cycle
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= {2'b00, idx, 2'b00}; pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    // Each pass waits one rising edge and looks at pready as it stood there
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(0, 1, "apb no ready");
    rd = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] r; logic e;
    apb(1, idx, d, r, e);
  endtask
  task automatic rdc(input logic [15:0] idx, input logic [31:0] exp, input logic xe);
    logic [31:0] r; logic e;
    apb(0, idx, 0, r, e);
    chk(r, exp, "read data");
    chk({31'h0, e}, {31'h0, xe}, "read error");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] pw(input logic signed [15:0] a, input logic signed [15:0] b);
    logic signed [31:0] m;
    m = a * b;
    return {{16{m[30]}}, m[30:15]};
  endfunction
  function automatic logic [31:0] ab(input logic [31:0] x);
    return x[31] ? 32'h0 - x : x;
  endfunction
  // Drives one sample set and advances the expected accumulators
  task automatic put(input logic signed [15:0] v0, v1, v2, i0, i1, i2, q0, q1, q2);
    logic signed [15:0] vu[3]; logic signed [15:0] ii[3]; logic signed [15:0] qq[3];
    logic [31:0] p; logic [31:0] q; mmc_samp_s s;
    s.v = {v2, v1, v0}; s.i = {i2, i1, i0}; s.iq = {q2, q1, q0};
    ii = '{i0, i1, i2}; qq = '{q0, q1, q2}; vu[0] = v0;
    case (am[5:4])
      2'b00: vu[1] = v1;
      2'b01: vu[1] = v0 - v2;
      2'b10: vu[1] = -v0 - v2;
      default: vu[1] = -v0;
    endcase
    vu[2] = (cf[13:12] == 2'b01) ? v0 : (cf[13:12] == 2'b10) ? vu[1] : v2;
    @(posedge pclk);
    samp <= s; samp_valid <= 1;
    @(posedge pclk);
    samp_valid <= 0;
    for (int k = 0; k < 3; k++) begin
      p = pw(vu[k], ii[k]);
      q = pw(vu[k], qq[k]);
      ea[k] += (am[1:0] == 2'b01) ? (p[31] ? 32'h0 : p) : (am[1:0] == 2'b11) ? ab(p) : p;
      pa[k] += (am[1:0] == 2'b11) ? ab(p) : p;
      er[k] += (am[3:2] == 2'b10) ? (p[31] ? 32'h0 - q : q) : (am[3:2] == 2'b11) ? ab(q) : q;
      pr[k] += q;
    end
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic comp_all();
    for (int k = 0; k < 3; k++) begin
      chk(energy.act[k], ea[k], "energy active");
      chk(energy.react[k], er[k], "energy reactive");
      chk(pulse_acc.act[k], pa[k], "pulse active");
      chk(pulse_acc.react[k], pr[k], "pulse reactive");
    end
  endtask
  task automatic zc(input logic [2:0] z);
    @(posedge pclk);
    zero_cross <= z;
    @(posedge pclk);
    zero_cross <= 3'b000;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole sequence needs roughly two hundred cycles
  initial begin
    #200000;
    chk(0, 1, "watchdog expired");
    finish_test();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    rdc(MMC_IDX_CFG, 32'h0002, 0);
    rdc(MMC_IDX_MM, 32'h001C, 0);
    rdc(MMC_IDX_AM, 32'h0000, 0);
    wr(MMC_IDX_MM, 32'h00FF);
    rdc(MMC_IDX_MM, 32'h001C, 0);
    rdc(16'hE702, 32'h0000, 1);
    // Raw phase B is zero, so the raw mode gives zero rms and the delta mode a nonzero rms
    put(16'h2000, 16'h0000, 16'h0800, 16'h0100, 16'h0100, 16'h0100, 0, 0, 0);
    chk({16'h0, phase_b_voltage_rms}, 32'h0, "rms raw phase B");
    am = 8'h10;
    wr(MMC_IDX_AM, {24'h0, am});
    put(16'h2000, 16'h0000, 16'h0800, 16'h0100, 16'h0100, 16'h0100, 0, 0, 0);
    chk({31'h0, phase_b_voltage_rms === 16'h0}, 0, "rms delta");
    // Phase B pulse terms still count here; dropping them is left to software
    comp_all();
    // Every active, reactive and topology code, with mixed power signs
    for (int a = 0; a < 4; a++) begin
      am = {2'b00, a[1:0], a[1:0], a[1:0]};
      wr(MMC_IDX_AM, {24'h0, am});
      comp_all();
      put(16'h2000, 16'h1000, -16'sh1000, 16'h1000, -16'sh0800, 16'h0C00,
          -16'sh0400, 16'h0600, 16'h0800);
      comp_all();
    end
    am = 8'h00;
    wr(MMC_IDX_AM, 32'h0);
    for (int c = 0; c < 4; c++) begin
      cf = {2'b00, c[1:0], 12'h002};
      wr(MMC_IDX_CFG, {16'h0, cf});
      rdc(MMC_IDX_CFG, {16'h0, cf}, 0);
      put(16'h2000, 16'h1000, -16'sh1000, 16'h1000, -16'sh0800, 16'h0C00,
          -16'sh0400, 16'h0600, 16'h0800);
      comp_all();
    end
    // Peaks: phase A alone, then all phases sharing one count of two
    wr(MMC_IDX_MM, 32'h0004);
    rdc(MMC_IDX_MM, 32'h0004, 0);
    wr(MMC_IDX_PCYC, 32'h0002);
    zc(3'b001);
    zc(3'b001);
    put(16'h1000, 16'h3000, 16'h3000, 16'h0100, 16'h0200, 16'h0200, 0, 0, 0);
    zc(3'b010);
    zc(3'b100);
    zc(3'b001);
    zc(3'b001);
    chk({16'h0, volt_peak}, 32'h1000, "voltage peak A");
    chk({16'h0, curr_peak}, 32'h0100, "current peak A");
    wr(MMC_IDX_MM, 32'h001C);
    put(16'h1000, 16'h3000, 16'h2000, 16'h0100, 16'h0400, 16'h0200, 0, 0, 0);
    zc(3'b001);
    zc(3'b010);
    chk({16'h0, volt_peak}, 32'h3000, "voltage peak all");
    chk({16'h0, curr_peak}, 32'h0400, "current peak all");
    rdc(MMC_IDX_VPK, 32'h3000, 0);
    rdc(MMC_IDX_IPK, 32'h0400, 0);
    finish_test();
  end
endmodule
